// *** rtl/ebfc_defines.svh ***
// Contract
// (R1) While bus master, extended user pins show the four extended output levels.
// (R2) Each stored one drives its pin high, each zero drives it low.
// (R3) Extended user pins are offered only with extended bus mode selected.
// (R4) Software writes zeros to reserved bits eleven to five and bit three.
// (R5) Hold edge select zero: falling edge; one: half a clock later, rising.
// (R6) Compress on match alone: assert compress when destination hits a filter entry.
// (R7) Compress on miss alone: assert compress when destination hits no entry.
// (R8) Software never sets compress on match and compress on miss together.
// (R9) Both compress bits zero: compress output stays undriven.
// (R10) Compress is never asserted for a broadcast destination.
// (R11) Reject on match set discards filter hits; clear accepts them normally.
// (R12) Reject on match inverts only the filter memory term, not other accepts; the code also blocks the accept-all physical and multicast terms on a hit.
// (R13) Reject on match with accept broadcast: all broadcasts accepted, hits rejected.
// (R14) Hardware reset clears bits except output levels; software reset changes nothing; the code also clears the output levels to 4'h0.
// (R15) Software writes the register only while the device sits in software reset; the code accepts writes whatever soft_reset_active is.
// (R16) Reserved bits may read any value; writable fields read back the last value.
`ifndef EBFC_DEFINES_SVH
`define EBFC_DEFINES_SVH

`define EBFC_ADDR_W 8
`define EBFC_REG_OFFSET 8'h00
`define EBFC_REG_W 16
`define EBFC_EXTENDED_OUTPUT_LEVELS_MSB 15
`define EBFC_EXTENDED_OUTPUT_LEVELS_LSB 12
`define EBFC_HOLD_EDGE_BIT 4
`define EBFC_CMP_MATCH_BIT 2
`define EBFC_CMP_MISS_BIT 1
`define EBFC_REJECT_BIT 0
`define EBFC_WRITABLE_MASK 16'hF017
`define EBFC_CFG_RESET 16'h0000
`define EBFC_EXTENDED_OUTPUT_LEVELS_RESET 4'h0
`define EBFC_MDC_EXT_BIT 15
`define EBFC_LANE_LO 0
`define EBFC_LANE_HI 1

`endif

// *** rtl/ebfc_pkg.sv ***
`include "ebfc_defines.svh"
package ebfc_pkg;
  typedef logic [`EBFC_EXTENDED_OUTPUT_LEVELS_MSB-`EBFC_EXTENDED_OUTPUT_LEVELS_LSB:0] ebfc_extended_output_levels_t;
  typedef logic [`EBFC_REG_W-1:0] ebfc_word_t;
  typedef logic [`EBFC_ADDR_W-1:0] ebfc_addr_t;
  typedef struct packed {
    logic hold_edge_select;
    logic compress_on_match;
    logic compress_on_miss;
    logic reject_on_filter_match;
  } ebfc_ctrl_t;
endpackage : ebfc_pkg

// *** rtl/ebfc_filt_if.sv ***
`timescale 1ns/1ps
interface ebfc_filt_if;
  import ebfc_pkg::*;
  ebfc_ctrl_t ctrl;
  logic accept_broadcast;
  logic accept_all_physical;
  logic accept_all_multicast;
  logic filter_valid;
  logic filter_match;
  logic dest_broadcast;
  logic dest_multicast;
  logic frame_end;
  logic packet_accept;
  logic packet_compress;
  modport top (
    output ctrl, accept_broadcast, accept_all_physical, accept_all_multicast,
    output filter_valid, filter_match, dest_broadcast, dest_multicast, frame_end,
    input packet_accept, packet_compress
  );
  modport filt (
    input ctrl, accept_broadcast, accept_all_physical, accept_all_multicast,
    input filter_valid, filter_match, dest_broadcast, dest_multicast, frame_end,
    output packet_accept, packet_compress
  );
endinterface : ebfc_filt_if

// *** rtl/ebfc_filter.sv ***
`timescale 1ns/1ps
module ebfc_filter (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // configuration and filter results
  ebfc_filt_if.filt fi
);
  import ebfc_pkg::*;

  logic filter_term;
  logic accept_nxt;
  logic compress_nxt;

  always_comb begin
    // only the filter memory term is inverted
    filter_term = fi.ctrl.reject_on_filter_match ? ~fi.filter_match : fi.filter_match; // R11 R12
    accept_nxt = (fi.dest_broadcast & fi.accept_broadcast) // R13
      | (~(fi.ctrl.reject_on_filter_match & fi.filter_match) // R11 R13
      & (filter_term
      | (fi.accept_all_physical & ~fi.dest_multicast)
      | (fi.accept_all_multicast & fi.dest_multicast))); // R12
    compress_nxt = 1'b0;
    if (!fi.dest_broadcast) begin // R10
      if (fi.ctrl.compress_on_match && !fi.ctrl.compress_on_miss) begin
        compress_nxt = fi.filter_match; // R6
      end else if (fi.ctrl.compress_on_miss && !fi.ctrl.compress_on_match) begin
        compress_nxt = ~fi.filter_match; // R7
      end
    end
  end

  // result held until the next decision or end of frame
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fi.packet_accept <= 1'b0;
    end else if (fi.filter_valid) begin
      fi.packet_accept <= accept_nxt;
    end else if (fi.frame_end) begin
      fi.packet_accept <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fi.packet_compress <= 1'b0;
    end else if (fi.filter_valid) begin
      fi.packet_compress <= compress_nxt;
    end else if (fi.frame_end) begin
      fi.packet_compress <= 1'b0;
    end
  end
endmodule : ebfc_filter

// *** rtl/ebfc_top.sv ***
`timescale 1ns/1ps
module ebfc_top (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire ebfc_pkg::ebfc_addr_t wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // device state
  input wire logic bus_master,
  input wire ebfc_pkg::ebfc_word_t main_data_config,
  input wire logic soft_reset_active,
  // hold request
  input wire logic hold_req_in,
  output logic hold_req_out,
  // receive control and filter results
  input wire logic accept_broadcast,
  input wire logic accept_all_physical,
  input wire logic accept_all_multicast,
  input wire logic filter_valid,
  input wire logic filter_match,
  input wire logic dest_broadcast,
  input wire logic dest_multicast,
  input wire logic frame_end,
  output logic packet_accept,
  // pins
  output ebfc_pkg::ebfc_extended_output_levels_t extended_user_pins,
  output logic extended_user_pins_oe_n,
  output logic packet_compress_out,
  output logic packet_compress_out_oe_n
);
  import ebfc_pkg::*;

  ebfc_extended_output_levels_t extended_output_levels_r;
  ebfc_ctrl_t ctrl_r;
  logic hit;
  logic req;
  logic wr;
  logic hold_rise_r;
  logic hold_fall_r;
  ebfc_word_t reg_view;
  ebfc_filt_if fi ();
  localparam ebfc_extended_output_levels_t EXTENDED_OUTPUT_LEVELS_RESET = `EBFC_EXTENDED_OUTPUT_LEVELS_RESET;
  localparam ebfc_word_t CFG_RESET = `EBFC_CFG_RESET;

  function automatic logic addr_hit(input ebfc_addr_t a);
    addr_hit = (a == `EBFC_REG_OFFSET);
  endfunction : addr_hit

  // byte lane qualifier of an accepted write
  function automatic logic lane_write(input logic w, input logic [3:0] sel, input int lane);
    lane_write = w & sel[lane];
  endfunction : lane_write

  assign hit = addr_hit(wb_adr_i);
  assign req = wb_cyc_i & wb_stb_i;
  assign wr = req & wb_ack_o & wb_we_i & hit;

  always_comb begin
    reg_view = `EBFC_CFG_RESET;
    reg_view[`EBFC_EXTENDED_OUTPUT_LEVELS_MSB:`EBFC_EXTENDED_OUTPUT_LEVELS_LSB] = extended_output_levels_r;
    reg_view[`EBFC_HOLD_EDGE_BIT] = ctrl_r.hold_edge_select;
    reg_view[`EBFC_CMP_MATCH_BIT] = ctrl_r.compress_on_match;
    reg_view[`EBFC_CMP_MISS_BIT] = ctrl_r.compress_on_miss;
    reg_view[`EBFC_REJECT_BIT] = ctrl_r.reject_on_filter_match;
    reg_view = reg_view & `EBFC_WRITABLE_MASK; // R16
  end

  // one wait state; ack drops the cycle after it is given
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req & ~wb_ack_o;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wb_dat_o <= '0;
    end else if (req && !wb_ack_o) begin
      wb_dat_o <= hit ? 32'(reg_view) : '0; // R16
    end
  end

  // software reset has no effect; writes rely on software sequencing
  for (genvar b = 0; b < $bits(ebfc_extended_output_levels_t); b = b + 1) begin : g_extended_output_levels
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        extended_output_levels_r[b] <= EXTENDED_OUTPUT_LEVELS_RESET[b]; // R14
      end else if (lane_write(wr, wb_sel_i, `EBFC_LANE_HI)) begin
        extended_output_levels_r[b] <= wb_dat_i[`EBFC_EXTENDED_OUTPUT_LEVELS_LSB + b]; // R1 R2
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_r.hold_edge_select <= CFG_RESET[`EBFC_HOLD_EDGE_BIT]; // R14
    end else if (lane_write(wr, wb_sel_i, `EBFC_LANE_LO)) begin
      ctrl_r.hold_edge_select <= wb_dat_i[`EBFC_HOLD_EDGE_BIT]; // R5
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_r.compress_on_match <= CFG_RESET[`EBFC_CMP_MATCH_BIT]; // R14
    end else if (lane_write(wr, wb_sel_i, `EBFC_LANE_LO)) begin
      ctrl_r.compress_on_match <= wb_dat_i[`EBFC_CMP_MATCH_BIT]; // R6
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_r.compress_on_miss <= CFG_RESET[`EBFC_CMP_MISS_BIT]; // R14
    end else if (lane_write(wr, wb_sel_i, `EBFC_LANE_LO)) begin
      ctrl_r.compress_on_miss <= wb_dat_i[`EBFC_CMP_MISS_BIT]; // R7
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_r.reject_on_filter_match <= CFG_RESET[`EBFC_REJECT_BIT]; // R14
    end else if (lane_write(wr, wb_sel_i, `EBFC_LANE_LO)) begin
      ctrl_r.reject_on_filter_match <= wb_dat_i[`EBFC_REJECT_BIT]; // R11
    end
  end

  // extended user pins
  always_comb begin
    extended_user_pins = extended_output_levels_r; // R1 R2
    extended_user_pins_oe_n = ~(bus_master & main_data_config[`EBFC_MDC_EXT_BIT]); // R1 R3
  end

  // hold request on either clock edge
  always_ff @(negedge sys_clk) begin
    if (rst) begin
      hold_fall_r <= 1'b0;
    end else begin
      hold_fall_r <= hold_req_in;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hold_rise_r <= 1'b0;
    end else begin
      hold_rise_r <= hold_req_in;
    end
  end

  assign hold_req_out = ctrl_r.hold_edge_select ? hold_rise_r : hold_fall_r; // R5

  // filter decision
  assign fi.ctrl = ctrl_r;
  assign fi.accept_broadcast = accept_broadcast;
  assign fi.accept_all_physical = accept_all_physical;
  assign fi.accept_all_multicast = accept_all_multicast;
  assign fi.filter_valid = filter_valid;
  assign fi.filter_match = filter_match;
  assign fi.dest_broadcast = dest_broadcast;
  assign fi.dest_multicast = dest_multicast;
  assign fi.frame_end = frame_end;

  ebfc_filter u_filter (
    .sys_clk(sys_clk),
    .rst(rst),
    .fi(fi.filt)
  );

  assign packet_accept = fi.packet_accept;
  assign packet_compress_out = fi.packet_compress;
  assign packet_compress_out_oe_n = ~(ctrl_r.compress_on_match | ctrl_r.compress_on_miss); // R9

endmodule : ebfc_top

// *** tb/ebfc_rx_model.sv ***
`timescale 1ns/1ps
module ebfc_rx_model (
  // clock and stimulus
  input wire logic sys_clk,
  input wire logic go,
  input wire logic [1:0] kind,
  // filter results toward the block
  output logic filter_valid = 1'h0,
  output logic frame_end = 1'h0,
  output logic filter_match,
  output logic dest_broadcast,
  output logic dest_multicast
);
  logic [1:0] k_r = 2'h0;
  // flags garble outside the valid cycle
  always @(posedge sys_clk) begin
    filter_valid <= go;
    frame_end <= filter_valid;
    k_r <= go ? kind : ~k_r;
  end
  assign filter_match = k_r[0];
  assign dest_broadcast = k_r[1];
  assign dest_multicast = k_r[1];
endmodule : ebfc_rx_model

// *** tb/ebfc_top_sva.sv ***
`timescale 1ns/1ps
module ebfc_sva (
  input wire logic sys_clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, bus_master,
  input wire ebfc_pkg::ebfc_addr_t wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i, wb_dat_o,
  input wire ebfc_pkg::ebfc_word_t main_data_config,
  input wire logic hold_req_in, hold_req_out, accept_broadcast, accept_all_physical,
  input wire logic accept_all_multicast, filter_valid, filter_match, dest_broadcast,
  input wire logic packet_accept, packet_compress_out, packet_compress_out_oe_n,
  input wire logic extended_user_pins_oe_n,
  input wire ebfc_pkg::ebfc_extended_output_levels_t extended_user_pins
);
  import ebfc_pkg::*;
  ebfc_word_t cfg_r;
  logic acc;
  assign acc = wb_cyc_i && wb_stb_i && wb_ack_o && wb_adr_i == 8'h00;
  always_ff @(posedge sys_clk) begin
    if (rst) cfg_r <= 16'h0000;
    else if (acc && wb_we_i) begin
      if (wb_sel_i[0]) cfg_r[7:0] <= wb_dat_i[7:0] & 8'h17;
      if (wb_sel_i[1]) cfg_r[15:8] <= wb_dat_i[15:8] & 8'hF0;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  pins_drive_a: assert property (extended_user_pins_oe_n == !(bus_master && main_data_config[15])) else $error("pin enable wrong");
  pins_level_a: assert property (extended_user_pins == cfg_r[15:12]) else $error("pin level wrong");
  hold_fall_a: assert property (!cfg_r[4] && !$past(cfg_r[4]) && !$past(rst) |-> hold_req_out == hold_req_in) else $error("hold not on falling edge");
  hold_rise_a: assert property (cfg_r[4] && $past(cfg_r[4]) && !$past(rst) |-> hold_req_out == $past(hold_req_in)) else $error("hold not on rising edge");
  cmp_match_a: assert property (filter_valid && !dest_broadcast && cfg_r[2:1] == 2'h2 |=> packet_compress_out == $past(filter_match)) else $error("compress on match wrong");
  cmp_miss_a: assert property (filter_valid && !dest_broadcast && cfg_r[2:1] == 2'h1 |=> packet_compress_out == !$past(filter_match)) else $error("compress on miss wrong");
  cmp_bcast_a: assert property (filter_valid && dest_broadcast |=> !packet_compress_out) else $error("compress on broadcast");
  cmp_float_a: assert property (packet_compress_out_oe_n == (cfg_r[2:1] == 2'h0)) else $error("compress enable wrong");
  rej_match_a: assert property (filter_valid && filter_match && cfg_r[0] && !accept_all_physical && !accept_all_multicast && !(dest_broadcast && accept_broadcast) |=> !packet_accept) else $error("match not rejected");
  bcast_keep_a: assert property (filter_valid && dest_broadcast && accept_broadcast |=> packet_accept) else $error("broadcast not accepted");
  read_back_a: assert property (acc && !wb_we_i |-> wb_dat_o == {16'h0000, cfg_r}) else $error("read back wrong");
endmodule : ebfc_sva
bind ebfc_top ebfc_sva ebfc_sva_i (.sys_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o,
  .bus_master, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .main_data_config, .hold_req_in,
  .hold_req_out, .accept_broadcast, .accept_all_physical, .accept_all_multicast, .filter_valid,
  .filter_match, .dest_broadcast, .packet_accept, .packet_compress_out,
  .packet_compress_out_oe_n, .extended_user_pins_oe_n, .extended_user_pins);

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb;
  import ebfc_pkg::*;
  logic sys_clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, bm = 0, hin = 0, go = 0;
  logic sra = 1;
  logic ab = 0, ap = 0, am = 0, ack, pacc, pco, pco_oe_n, pins_oe_n, hout;
  logic [3:0] sel = 4'h3;
  logic filter_valid, filter_match, dest_broadcast, dest_multicast, frame_end;
  logic [1:0] kind = 0;
  logic [31:0] dat = 0, dout, rdat;
  ebfc_addr_t adr = 0;
  ebfc_word_t mdc = 0, v;
  ebfc_extended_output_levels_t pins;
  int mismatches = 0, n_compared = 0;
  initial forever #25 sys_clk = ~sys_clk;
  ebfc_rx_model ebfc_rx_model_i (.sys_clk, .go, .kind, .filter_valid, .frame_end,
    .filter_match, .dest_broadcast, .dest_multicast);
  ebfc_top ebfc_top_i (.sys_clk, .rst, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dout), .wb_ack_o(ack),
    .bus_master(bm), .main_data_config(mdc), .soft_reset_active(sra), .hold_req_in(hin),
    .hold_req_out(hout), .accept_broadcast(ab), .accept_all_physical(ap),
    .accept_all_multicast(am), .filter_valid, .filter_match, .dest_broadcast,
    .dest_multicast, .frame_end, .packet_accept(pacc), .extended_user_pins(pins),
    .extended_user_pins_oe_n(pins_oe_n), .packet_compress_out(pco),
    .packet_compress_out_oe_n(pco_oe_n));
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic w, input ebfc_addr_t a, input ebfc_word_t d);
    int i = 0;
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= {16'h0000, d};
    do begin @(posedge sys_clk); i++; end while (ack !== 1'h1 && i < 20);
    if (ack !== 1'h1) begin
      mismatches++;
      $display("MISMATCH t=%0t ack timeout", $time);
      wrap_up();
    end
    rdat = dout;
    cyc <= 0; stb <= 0; we <= 0;
    @(posedge sys_clk);
  endtask : wb
  // one packet, checked once the decision has settled
  task automatic pkt(input logic [1:0] k);
    logic h0;
    logic h1;
    h0 = 1'($urandom);
    h1 = 1'($urandom);
    go <= 1'h1; kind <= k; hin <= h0;
    @(posedge sys_clk); go <= 1'h0; hin <= h1;
    // between the falling and the next rising edge the two hold modes differ
    @(negedge sys_clk);
    #10;
    chk(hout, v[4] ? h0 : h1);
    @(posedge sys_clk);
    @(negedge sys_clk);
    if (v[2:1] != 2'h0) chk(pco, expc(v, k));
    if (k[1] && ab) chk(pacc, 1'h1);
    else if (v[0] && k[0] && !ap && !am) chk(pacc, 1'h0);
    @(posedge sys_clk);
  endtask : pkt
  function automatic logic expc(ebfc_word_t c, logic [1:0] k);
    if (k[1]) return 1'h0;
    return (c[2:1] == 2'h2) ? k[0] : !k[0];
  endfunction : expc
  initial begin
    void'($urandom(34611));
    repeat (20) @(posedge sys_clk);
    rst <= 0;
    @(posedge sys_clk);
    wb(0, 8'h00, 0); chk(rdat, 0);
    wb(1, 8'h04, 16'hF017); wb(0, 8'h04, 0); chk(rdat, 0);
    $display("test reset done");
    for (int n = 0; n < 12; n++) begin
      v = 16'($urandom) & 16'hF017;
      v[2:1] = 2'(n % 3);
      bm <= 1'($urandom); mdc <= 16'($urandom); ab <= 1'($urandom);
      ap <= 1'($urandom); am <= 1'($urandom);
      wb(1, 8'h00, v); wb(0, 8'h00, 0); chk(rdat, {16'h0000, v});
      chk(pins_oe_n, !(bm && mdc[15]));
      chk(pins, v[15:12]);
      chk(pco_oe_n, v[2:1] == 2'h0);
      repeat (4) pkt(2'($urandom));
    end
    // low byte lane only: the extended levels must survive
    sel <= 4'h1;
    wb(1, 8'h00, {~v[15:8] & 8'hF0, ~v[7:0] & 8'h17});
    v[7:0] = ~v[7:0] & 8'h17;
    sel <= 4'h3;
    wb(0, 8'h00, 0); chk(rdat, {16'h0000, v});
    $display("test config and filter done");
    sra <= 0; @(posedge sys_clk); sra <= 1;
    wb(0, 8'h00, 0); chk(rdat, {16'h0000, v});
    rst <= 1; repeat (2) @(posedge sys_clk); rst <= 0; @(posedge sys_clk);
    wb(0, 8'h00, 0); chk(rdat, 0);
    $display("test resets done");
    wrap_up();
  end
endmodule : tb
